// ==== design/fbom_regs.svh ====
// Register offsets, reset values and field positions of the overflow monitor
`ifndef FBOM_REGS_SVH
`define FBOM_REGS_SVH
// ==========================================
// Register offsets
`define FBOM_ADR_SYNC_LVL 8'h00
`define FBOM_ADR_IMM_LVL 8'h04
`define FBOM_ADR_REL_LVL 8'h08
`define FBOM_ADR_FILTER 8'h0c
`define FBOM_ADR_FILL 8'h10
`define FBOM_ADR_OVF 8'h14
`define FBOM_ADR_STATE 8'h18
// ==========================================
// Levels in half-percent steps; FBOM_PCT_FULL is the whole-percent full scale of the fill level
`define FBOM_SYNC_LVL_RST 8'ha0
`define FBOM_IMM_LVL_RST 8'hc7
`define FBOM_REL_LVL_RST 8'h64
`define FBOM_LVL_MAX 8'hc8
`define FBOM_HALF_PCT_FULL 200
`define FBOM_PCT_FULL 100
// ==========================================
// Event word layout
`define FBOM_FID_W 16
`define FBOM_BIT_TRUNC 32
`define FBOM_BIT_LOST 33
`define FBOM_BIT_GOOD 34
`define FBOM_TS_W 32
`endif

// ==== design/fbom_pkg.sv ====
// Types and helper functions of the overflow monitor
`include "fbom_regs.svh"
package fbom_pkg;
    typedef enum logic [2:0] {
        filter_truncated_only,
        filter_dropped_only,
        filter_truncated_or_dropped,
        filter_good_only,
        filter_truncated_or_good,
        filter_dropped_or_good,
        filter_all
    } fbom_filter_t;

    typedef enum logic [1:0] {st_idle, st_accept, st_cut, st_discard} fbom_state_t;

    typedef struct packed {
        logic done;
        logic trunc;
        logic lost;
        logic [`FBOM_FID_W-1:0] fid;
        logic [`FBOM_TS_W-1:0] ts;
    } fbom_frame_end_t;

    typedef struct packed {
        logic [63:0] word;
        logic [`FBOM_TS_W-1:0] ts;
    } fbom_event_t;

    // Occupancy scaled to full, rounded down
    function automatic logic [7:0] fbom_scale(input int unsigned cnt, input int unsigned depth,
                                              input int unsigned full);
        return 8'((cnt * full) / depth);
    endfunction
endpackage

// ==== design/fbom_frame_fifo.sv ====
// Frame buffer memory with registered output stage towards DMA
module fbom_frame_fifo #(
    parameter int DW = 32,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Write side
    input wire logic wr_en,
    input wire logic [DW-1:0] wr_data,
    input wire logic wr_last,
    input wire logic wr_trunc,
    output logic [$clog2(DEPTH+1)-1:0] count,
    // DMA side
    output logic out_valid,
    output logic [DW-1:0] out_data,
    output logic out_last,
    output logic out_trunc,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [DW+1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ov_q, ov_d, rd_en;
    logic [DW+1:0] ob_q, ob_d;

    // ==========================================
    // Pointers and output stage
    always_comb begin
        rd_en = (cnt_q != '0) && (!ov_q || out_ready);
        wp_d = wr_en ? wp_q + 1'b1 : wp_q;
        rp_d = rd_en ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + CW'(wr_en) - CW'(rd_en);
        ov_d = rd_en ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        ob_d = rd_en ? mem[rp_q] : ob_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            ob_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            ob_q <= ob_d;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wp_q] <= {wr_trunc, wr_last, wr_data};
        end
    end

    assign count = cnt_q;
    assign out_valid = ov_q;
    assign out_data = ob_q[DW-1:0];
    assign out_last = ob_q[DW];
    assign out_trunc = ob_q[DW+1];
endmodule // fbom_frame_fifo

// ==== design/fbom_event_pack.sv ====
// Per-frame event filter and 64-bit event word packing
`include "fbom_regs.svh"
module fbom_event_pack (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Frame classification
    input wire fbom_pkg::fbom_filter_t filter,
    input wire fbom_pkg::fbom_frame_end_t frame_end,
    // Event output
    output logic evt_valid,
    output fbom_pkg::fbom_event_t evt
);
    logic v_q, v_d;
    fbom_pkg::fbom_event_t e_q, e_d;

    function automatic logic wanted(input fbom_pkg::fbom_filter_t f, input logic t, input logic l);
        logic g;
        g = !t && !l;
        case (f)
            fbom_pkg::filter_truncated_only: return t;
            fbom_pkg::filter_dropped_only: return l;
            fbom_pkg::filter_truncated_or_dropped: return t || l;
            fbom_pkg::filter_good_only: return g;
            fbom_pkg::filter_truncated_or_good: return t || g;
            fbom_pkg::filter_dropped_or_good: return l || g;
            fbom_pkg::filter_all: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ==========================================
    // Packing
    always_comb begin
        v_d = frame_end.done && wanted(filter, frame_end.trunc, frame_end.lost); // [R5] [R6] [R7]
        e_d = e_q;
        if (v_d) begin
            e_d.word = '0;
            e_d.word[`FBOM_FID_W-1:0] = frame_end.fid; // [R9]
            e_d.word[`FBOM_BIT_TRUNC] = frame_end.trunc && !frame_end.lost; // [R10] [R20] [R15]
            e_d.word[`FBOM_BIT_LOST] = frame_end.lost; // [R20]
            e_d.word[`FBOM_BIT_GOOD] = !frame_end.trunc && !frame_end.lost; // [R20]
            e_d.ts = frame_end.ts; // [R8]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            v_q <= 1'b0;
            e_q <= '0;
        end else begin
            v_q <= v_d;
            e_q <= e_d;
        end
    end

    assign evt_valid = v_q;
    assign evt = e_q;
endmodule // fbom_event_pack

// ==== design/fbom_monitor.sv ====
// Frame buffer overflow monitor: thresholds, frame classification, registers
//
// Functional notes
// R1: Boundary overflow only after current frame stored
// R2: Drop frames while boundary level exceeded
// R3: One boundary level, no hysteresis
// R4: Levels 0 to 100 percent, half steps
// R5: Single-class filter: one event per frame
// R6: Pair filter; default truncated or dropped
// R7: All filter: event for every frame
// R8: Event carries type, frame id, timestamp
// R9: Event word bits 15:0 frame id
// R10: Status mask in event bits 47:32
// R11: Frame id taken from camera stream
// R12: Frame id sixteen bits, wraps to zero
// R13: Truncated frame still sent, shortened
// R14: Lost frame never written to buffer
// R15: Truncated and lost never both set
// R16: Immediate level cuts current frame at once
// R17: Leave immediate overflow below release level
// R18: Overflow flag clears on read
// R19: Fill level readable as whole percent
// R20: Bit 32 truncated, 33 lost, 34 complete
//
// Implementation choices: strobed register access and the register offsets.
`include "fbom_regs.svh"
module fbom_monitor #(
    parameter int DW = 32,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Camera stream
    input wire logic in_valid,
    input wire logic in_sof,
    input wire logic in_eof,
    input wire logic [DW-1:0] in_data,
    input wire logic [`FBOM_FID_W-1:0] in_frame_id,
    // DMA stream
    output logic out_valid,
    output logic [DW-1:0] out_data,
    output logic out_last,
    output logic out_trunc,
    input wire logic out_ready,
    // Events
    output logic evt_valid,
    output fbom_pkg::fbom_event_t evt
);
    localparam int CW = $clog2(DEPTH+1);

    fbom_pkg::fbom_state_t state_q, state_d;
    fbom_pkg::fbom_filter_t filter_q, filter_d;
    fbom_pkg::fbom_frame_end_t fe_q, fe_d;
    logic [7:0] sync_lvl_q, sync_lvl_d, imm_lvl_q, imm_lvl_d, rel_lvl_q, rel_lvl_d;
    logic [7:0] fill_pct_q, fill_pct_d, occ_half;
    logic [31:0] rdata_q, rdata_d;
    logic [`FBOM_TS_W-1:0] ts_q;
    logic [`FBOM_FID_W-1:0] fid_q, fid_d;
    logic imm_ovf_q, imm_ovf_d, sync_ovf_q, sync_ovf_d, ovf_q, ovf_d;
    logic [CW-1:0] fifo_count;
    logic fifo_wr, wr_last, wr_trunc;
    logic sync_hit, imm_hit, near_full, cut_cond, drop_now, take_word, ovf_set;

    function automatic logic [7:0] clamp_lvl(input logic [31:0] v);
        return (v > 32'(`FBOM_LVL_MAX)) ? `FBOM_LVL_MAX : v[7:0];
    endfunction

    // ==========================================
    // Buffer and event packer
    fbom_frame_fifo #(.DW(DW), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(fifo_wr),
        .wr_data(in_data),
        .wr_last(wr_last),
        .wr_trunc(wr_trunc),
        .count(fifo_count),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_last(out_last),
        .out_trunc(out_trunc),
        .out_ready(out_ready)
    );

    fbom_event_pack u_evt (
        .clk(clk),
        .sys_rst(sys_rst),
        .filter(filter_q),
        .frame_end(fe_q),
        .evt_valid(evt_valid),
        .evt(evt)
    );

    // ==========================================
    // Occupancy comparison
    always_comb begin
        occ_half = fbom_pkg::fbom_scale(32'(fifo_count), DEPTH, `FBOM_HALF_PCT_FULL);
        sync_hit = occ_half > sync_lvl_q; // [R3]
        imm_hit = occ_half > imm_lvl_q; // [R16]
        near_full = fifo_count >= CW'(DEPTH - 1);
        cut_cond = imm_ovf_q || imm_hit || near_full;
        drop_now = imm_ovf_q || sync_ovf_d || (fifo_count == CW'(DEPTH)); // [R2] [R17] [R14]
        take_word = in_valid && ((state_q == fbom_pkg::st_accept) ||
                    (state_q == fbom_pkg::st_idle && in_sof && !drop_now));
    end

    // ==========================================
    // Frame state machine
    always_comb begin
        state_d = state_q;
        fid_d = fid_q;
        fifo_wr = 1'b0;
        wr_last = in_eof;
        wr_trunc = 1'b0;
        fe_d = fe_q;
        fe_d.done = 1'b0;
        // Boundary level only sampled between frames
        sync_ovf_d = (state_q == fbom_pkg::st_idle) ? sync_hit : sync_ovf_q; // [R1] [R3]
        if (imm_hit) begin
            imm_ovf_d = 1'b1; // [R16]
        end else if (occ_half < rel_lvl_q) begin
            imm_ovf_d = 1'b0; // [R17]
        end else begin
            imm_ovf_d = imm_ovf_q;
        end
        if (state_q == fbom_pkg::st_idle && in_valid && in_sof) begin
            fid_d = in_frame_id; // [R11] [R12]
        end
        if (take_word) begin
            fifo_wr = 1'b1;
            if (cut_cond && !in_eof) begin
                wr_last = 1'b1; // [R13]
                wr_trunc = 1'b1; // [R13]
                imm_ovf_d = 1'b1; // [R16]
                state_d = fbom_pkg::st_cut;
            end else if (in_eof) begin
                state_d = fbom_pkg::st_idle;
                fe_d.done = 1'b1;
                fe_d.trunc = 1'b0;
                fe_d.lost = 1'b0;
            end else begin
                state_d = fbom_pkg::st_accept;
            end
        end else begin
            case (state_q)
                fbom_pkg::st_idle: begin
                    if (in_valid && in_sof) begin
                        state_d = in_eof ? fbom_pkg::st_idle : fbom_pkg::st_discard; // [R14]
                        fe_d.done = in_eof;
                        fe_d.trunc = 1'b0;
                        fe_d.lost = 1'b1;
                    end
                end
                fbom_pkg::st_cut, fbom_pkg::st_discard: begin
                    if (in_valid && in_eof) begin
                        state_d = fbom_pkg::st_idle;
                        fe_d.done = 1'b1;
                        fe_d.trunc = (state_q == fbom_pkg::st_cut); // [R15]
                        fe_d.lost = (state_q == fbom_pkg::st_discard); // [R15]
                    end
                end
                default: state_d = fbom_pkg::st_idle;
            endcase
        end
        fe_d.fid = fid_d; // [R11]
        fe_d.ts = ts_q; // [R8]
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= fbom_pkg::st_idle;
            fid_q <= '0;
            fe_q <= '0;
            sync_ovf_q <= 1'b0;
            imm_ovf_q <= 1'b0;
            ts_q <= '0;
        end else begin
            state_q <= state_d;
            fid_q <= fid_d;
            fe_q <= fe_d;
            sync_ovf_q <= sync_ovf_d;
            imm_ovf_q <= imm_ovf_d;
            ts_q <= ts_q + 1'b1;
        end
    end

    // ==========================================
    // Register file
    always_comb begin
        sync_lvl_d = sync_lvl_q;
        imm_lvl_d = imm_lvl_q;
        rel_lvl_d = rel_lvl_q;
        filter_d = filter_q;
        rdata_d = '0;
        fill_pct_d = fbom_pkg::fbom_scale(32'(fifo_count), DEPTH, `FBOM_PCT_FULL); // [R19]
        ovf_set = (fe_d.done && (fe_d.trunc || fe_d.lost)) || (imm_hit && !imm_ovf_q);
        if (reg_wr) begin
            case (reg_addr)
                `FBOM_ADR_SYNC_LVL: sync_lvl_d = clamp_lvl(reg_wdata); // [R4]
                `FBOM_ADR_IMM_LVL: imm_lvl_d = clamp_lvl(reg_wdata); // [R4]
                `FBOM_ADR_REL_LVL: rel_lvl_d = clamp_lvl(reg_wdata); // [R4]
                `FBOM_ADR_FILTER: begin
                    if (reg_wdata[2:0] <= 3'(fbom_pkg::filter_all)) begin
                        filter_d = fbom_pkg::fbom_filter_t'(reg_wdata[2:0]); // [R5] [R6] [R7]
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `FBOM_ADR_SYNC_LVL: rdata_d = {24'h0000_00, sync_lvl_q};
                `FBOM_ADR_IMM_LVL: rdata_d = {24'h0000_00, imm_lvl_q};
                `FBOM_ADR_REL_LVL: rdata_d = {24'h0000_00, rel_lvl_q};
                `FBOM_ADR_FILTER: rdata_d = {29'h0000_0000, filter_q};
                `FBOM_ADR_FILL: rdata_d = {24'h0000_00, fill_pct_q}; // [R19]
                `FBOM_ADR_OVF: rdata_d = {31'h0000_0000, ovf_q}; // [R18]
                `FBOM_ADR_STATE: rdata_d = {28'h0000_000, state_q, sync_ovf_q, imm_ovf_q};
                default: rdata_d = '0;
            endcase
        end
        // Set wins over the read clear
        if (ovf_set) begin
            ovf_d = 1'b1; // [R18]
        end else if (reg_rd && reg_addr == `FBOM_ADR_OVF) begin
            ovf_d = 1'b0; // [R18]
        end else begin
            ovf_d = ovf_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_lvl_q <= `FBOM_SYNC_LVL_RST;
            imm_lvl_q <= `FBOM_IMM_LVL_RST;
            rel_lvl_q <= `FBOM_REL_LVL_RST;
            filter_q <= fbom_pkg::filter_truncated_or_dropped; // [R6]
            fill_pct_q <= '0;
            ovf_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            sync_lvl_q <= sync_lvl_d;
            imm_lvl_q <= imm_lvl_d;
            rel_lvl_q <= rel_lvl_d;
            filter_q <= filter_d;
            fill_pct_q <= fill_pct_d;
            ovf_q <= ovf_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================
    // Checks
    a_accept_writes: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        state_q == fbom_pkg::st_accept && in_valid |-> fifo_wr)
        else $error("accepted word not stored");
    a_boundary_drop: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        state_q == fbom_pkg::st_idle && in_valid && in_sof && !in_eof && sync_hit
        |=> state_q == fbom_pkg::st_discard)
        else $error("frame not dropped above boundary level");
    a_single_level: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
        state_q == fbom_pkg::st_idle && in_valid && in_sof && !sync_hit && !imm_ovf_q &&
        fifo_count != CW'(DEPTH) |-> fifo_wr)
        else $error("frame refused below boundary level");
    a_level_range: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        sync_lvl_q <= `FBOM_LVL_MAX && imm_lvl_q <= `FBOM_LVL_MAX && rel_lvl_q <= `FBOM_LVL_MAX)
        else $error("level above full scale");
    a_filter_skip: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        fe_q.done && filter_q == fbom_pkg::filter_good_only && fe_q.lost |=> !evt_valid)
        else $error("event for unselected class");
    a_filter_all: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        fe_q.done && filter_q == fbom_pkg::filter_all |=> evt_valid)
        else $error("frame without event in all mode");
    a_event_id: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        fe_q.done ##1 evt_valid |-> evt.word[15:0] == $past(fe_q.fid) && evt.ts == $past(fe_q.ts))
        else $error("event id or time mismatch");
    a_mask_layout: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        evt_valid |-> evt.word[63:35] == '0 && evt.word[31:16] == '0 && $onehot(evt.word[34:32]))
        else $error("bad mask field");
    a_trunc_marked: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        take_word && cut_cond && !in_eof |-> wr_last && wr_trunc ##1 state_q == fbom_pkg::st_cut)
        else $error("truncated frame not closed");
    a_lost_no_write: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
        state_q == fbom_pkg::st_discard || state_q == fbom_pkg::st_cut |-> !fifo_wr)
        else $error("dropped data written");
    a_flags_exclusive: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
        evt_valid |-> !(evt.word[`FBOM_BIT_TRUNC] && evt.word[`FBOM_BIT_LOST]))
        else $error("truncated and lost together");
    a_release: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
        imm_ovf_q && !imm_hit && occ_half < rel_lvl_q && !take_word |=> !imm_ovf_q)
        else $error("immediate overflow not released");
    a_ovf_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
        reg_rd && reg_addr == `FBOM_ADR_OVF && !ovf_set |=> !ovf_q ##0 reg_rdata[0] == $past(ovf_q))
        else $error("overflow flag not cleared by read");
    a_fill_range: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
        fill_pct_q <= 8'd100)
        else $error("fill level above 100");
endmodule // fbom_monitor

// ==== test/fbom_stream_model.sv ====
// Camera stream source and DMA sink model for the overflow monitor
module fbom_stream_model #(
    parameter int DW = 32
) (
    // Clock
    input wire logic clk,
    // Camera stream
    output logic in_valid,
    output logic in_sof,
    output logic in_eof,
    output logic [DW-1:0] in_data,
    output logic [15:0] in_frame_id,
    // DMA stream
    input wire logic out_valid,
    input wire logic [DW-1:0] out_data,
    input wire logic out_last,
    input wire logic out_trunc,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    int beat = 0;
    int bad_data = 0;
    int fr_len[$];
    logic fr_trunc[$];

    // ==========================================
    // Camera source
    initial begin
        in_valid = 1'b0;
        in_sof = 1'b0;
        in_eof = 1'b0;
        in_data = 32'h0000_0000;
        in_frame_id = 16'h0000;
    end

    // Beat data holds frame id and beat index
    task automatic send(input logic [15:0] id, input int len);
        for (int i = 0; i < len; i++) begin
            in_valid <= 1'b1;
            in_sof <= (i == 0);
            in_eof <= (i == len - 1);
            in_data <= DW'({id, 16'(i)});
            in_frame_id <= id;
            @(posedge clk);
        end
        in_valid <= 1'b0;
        in_sof <= 1'b0;
        in_eof <= 1'b0;
        // Released lines do not keep the last value
        in_data <= DW'($urandom);
        in_frame_id <= 16'($urandom);
        @(posedge clk);
    endtask

    // ==========================================
    // DMA sink, randomly slow, stalled on demand
    initial out_ready = 1'b0;
    always @(posedge clk) begin
        out_ready <= !stall && ($urandom % 4 != 0);
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (out_data[15:0] !== 16'(beat))
                bad_data++;
            beat++;
            if (out_last === 1'b1) begin
                fr_len.push_back(beat);
                fr_trunc.push_back(out_trunc);
                beat = 0;
            end
        end
    end
endmodule // fbom_stream_model

// ==== test/tb.sv ====
// Self-checking testbench of the frame buffer overflow monitor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, in_data, out_data;
    logic in_valid, in_sof, in_eof, out_valid, out_last, out_trunc, out_ready, evt_valid;
    logic [15:0] in_frame_id;
    fbom_pkg::fbom_event_t evt;
    int n_mismatch = 0;
    int n_checks = 0;
    int bad_ts = 0;
    logic [63:0] evq[$];
    logic [31:0] last_ts = 32'h0000_0000;

    always #5 clk = ~clk;

    fbom_monitor #(.DW(32), .DEPTH(DEPTH)) fbom_monitor_i (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof),
        .in_data(in_data), .in_frame_id(in_frame_id), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_trunc(out_trunc), .out_ready(out_ready),
        .evt_valid(evt_valid), .evt(evt));

    fbom_stream_model #(.DW(32)) fbom_stream_model_i (.clk(clk), .in_valid(in_valid),
        .in_sof(in_sof), .in_eof(in_eof), .in_data(in_data), .in_frame_id(in_frame_id),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .out_trunc(out_trunc), .out_ready(out_ready));

    // ==========================================
    // Event capture
    always @(posedge clk) begin
        if (evt_valid === 1'b1) begin
            evq.push_back(evt.word);
            if (evt.ts <= last_ts)
                bad_ts++;
            last_ts = evt.ts;
        end
    end

    // ==========================================
    // Helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Class: 0 truncated, 1 lost, 2 complete
    function automatic logic [63:0] ev_word(input logic [15:0] id, input int cls);
        return {29'h0, cls == 2, cls == 1, cls == 0, 16'h0000, id};
    endfunction

    function automatic bit picks(input int f, input int cls);
        bit [2:0] m[7] = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
        return m[f][cls];
    endfunction

    task automatic frame(input logic [15:0] id, input int len, input int f, input int cls);
        fbom_stream_model_i.send(id, len);
        repeat (4) @(posedge clk);
        chk(64'(evq.size()), 64'(picks(f, cls)));
        if (evq.size() > 0)
            chk(evq.pop_front(), ev_word(id, cls));
        evq.delete();
    endtask

    task automatic dma_frame(input int lo, input int hi, input logic tr);
        int len;
        for (int i = 0; i < 3000 && fbom_stream_model_i.fr_len.size() == 0; i++)
            @(posedge clk);
        chk(64'(fbom_stream_model_i.fr_len.size() > 0), 64'd1);
        if (fbom_stream_model_i.fr_len.size() > 0) begin
            len = fbom_stream_model_i.fr_len.pop_front();
            chk(64'(len >= lo && len <= hi), 64'd1);
            chk(64'(fbom_stream_model_i.fr_trunc.pop_front()), 64'(tr));
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

    // ==========================================
    // Tests
    initial begin
        logic [31:0] v;
        logic [15:0] id;
        int len;
        v = $urandom(53);
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h00, v);
        chk(v, 32'h0000_00a0);
        rd(8'h04, v);
        chk(v, 32'h0000_00c7);
        rd(8'h08, v);
        chk(v, 32'h0000_0064);
        rd(8'h0c, v);
        chk(v, 32'h0000_0002);
        rd(8'h10, v);
        chk(v, 32'h0000_0000);
        rd(8'h14, v);
        chk(v, 32'h0000_0000);
        rd(8'h20, v);
        chk(v, 32'h0000_0000);
        wr(8'h00, 32'h0000_00c9);
        rd(8'h00, v);
        chk(v, 32'h0000_00c8);
        wr(8'h00, 32'h0000_00a0);
        $display("test reset done");
        for (int f = 0; f < 7; f++) begin
            wr(8'h0c, 32'(f));
            id = (f == 0) ? 16'hffff : (f == 1) ? 16'h0000 : 16'($urandom);
            len = 1 + $urandom % 6;
            frame(id, len, f, 2);
            dma_frame(len, len, 1'b0);
        end
        wr(8'h0c, 32'h0000_0007);
        rd(8'h0c, v);
        chk(v, 32'h0000_0006);
        $display("test filter done");
        fbom_stream_model_i.stall = 1'b1;
        repeat (4) @(posedge clk);
        frame(16'h0101, 7, 6, 2);
        frame(16'h0102, 7, 6, 2);
        frame(16'h0103, 7, 6, 1);
        frame(16'h0104, 7, 6, 1);
        wr(8'h0c, 32'h0000_0003);
        frame(16'h0106, 7, 3, 1);
        wr(8'h0c, 32'h0000_0006);
        rd(8'h10, v);
        chk(64'(v == 81 || v == 87), 64'd1);
        rd(8'h14, v);
        chk(v, 32'h0000_0001);
        rd(8'h14, v);
        chk(v, 32'h0000_0000);
        fbom_stream_model_i.stall = 1'b0;
        dma_frame(7, 7, 1'b0);
        dma_frame(7, 7, 1'b0);
        repeat (50) @(posedge clk);
        chk(64'(fbom_stream_model_i.fr_len.size()), 64'd0);
        frame(16'h0105, 7, 6, 2);
        dma_frame(7, 7, 1'b0);
        $display("test boundary done");
        wr(8'h00, 32'h0000_00c8);
        wr(8'h04, 32'h0000_0064);
        fbom_stream_model_i.stall = 1'b1;
        repeat (4) @(posedge clk);
        frame(16'h0201, 16, 6, 0);
        frame(16'h0202, 2, 6, 1);
        fbom_stream_model_i.stall = 1'b0;
        dma_frame(9, 12, 1'b1);
        repeat (50) @(posedge clk);
        frame(16'h0203, 3, 6, 2);
        dma_frame(3, 3, 1'b0);
        chk(64'(fbom_stream_model_i.bad_data), 64'd0);
        chk(64'(bad_ts), 64'd0);
        $display("test immediate done");
        complete_run();
    end
endmodule // tb
